// ===== hw/uefc_pkg.sv
// uefc_pkg: constants, field positions and types of the enhanced flow control block
// assumes byte addresses on a word-aligned Avalon-MM slave, data in bits 7:0
package uefc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [5:0] A_SCRATCH = 6'h00;
  localparam logic [5:0] A_FEAT    = 6'h04;
  localparam logic [5:0] A_ENH     = 6'h08;
  localparam logic [5:0] A_XON1    = 6'h0C;
  localparam logic [5:0] A_XON2    = 6'h10;
  localparam logic [5:0] A_XOFF1   = 6'h14;
  localparam logic [5:0] A_XOFF2   = 6'h18;
  localparam logic [5:0] A_IEN     = 6'h1C;
  localparam logic [5:0] A_FIFO    = 6'h20;
  localparam logic [5:0] A_MODEM   = 6'h24;
  localparam logic [5:0] A_DELAY   = 6'h28;
  localparam logic [5:0] A_STAT    = 6'h2C;
  localparam logic [7:0] SCRATCH_RST = 8'hFF;
  localparam logic [7:0] ZERO8       = 8'h00;
  localparam logic [7:0] IEN_PROT    = 8'hF0;
  localparam logic [7:0] FIFO_PROT   = 8'h30;
  localparam logic [7:0] MODEM_PROT  = 8'hE0;
  localparam logic [7:0] DELAY_PROT  = 8'hF0;
  localparam logic [7:0] STAT_W1C    = 8'h30;
  // ****************************************
  // field positions and encodings
  // ****************************************
  localparam int FC_IRPOL   = 4;
  localparam int FC_AUTO485 = 5;
  localparam int EF_ENH     = 4;
  localparam int EF_SPC     = 5;
  localparam int EF_ARTS    = 6;
  localparam int EF_ACTS    = 7;
  localparam int MC_DTR     = 0;
  localparam int MC_RTS     = 1;
  localparam int MC_SEL     = 2;
  localparam int ST_SPC     = 4;
  localparam int ST_XOFF    = 5;
  localparam logic [1:0] TBL_D    = 2'h3;
  localparam logic [1:0] SWF_NONE = 2'h0;
  localparam logic [1:0] SWF_1    = 2'h2;
  localparam logic [1:0] SWF_2    = 2'h1;
  localparam logic [1:0] SWF_BOTH = 2'h3;
  localparam logic [3:0] HYST_OFF = 4'h0;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE  = 4'h1;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } uefc_char_t;

  typedef enum logic [2:0] {
    R_RX  = 3'h1,
    R_TX  = 3'h2,
    R_DLY = 3'h4
  } uefc_dir_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'h1,
    S_FIRST  = 3'h2,
    S_SECOND = 3'h4
  } uefc_swtx_t;

  function automatic logic [7:0] uefc_hyst(input logic [3:0] s);
    case (s)
      4'h0: uefc_hyst = 8'h00;
      4'h1: uefc_hyst = 8'h04;
      4'h2: uefc_hyst = 8'h06;
      4'h3: uefc_hyst = 8'h08;
      4'h4: uefc_hyst = 8'h08;
      4'h5: uefc_hyst = 8'h10;
      4'h6: uefc_hyst = 8'h18;
      4'h7: uefc_hyst = 8'h20;
      4'h8: uefc_hyst = 8'h28;
      4'h9: uefc_hyst = 8'h2C;
      4'hA: uefc_hyst = 8'h30;
      4'hB: uefc_hyst = 8'h34;
      4'hC: uefc_hyst = 8'h0C;
      4'hD: uefc_hyst = 8'h14;
      4'hE: uefc_hyst = 8'h1C;
      default: uefc_hyst = 8'h24;
    endcase
  endfunction

  function automatic logic [7:0] uefc_merge(input logic [7:0] old, input logic [7:0] wd,
                                            input logic [7:0] prot, input logic en);
    uefc_merge = (wd & ~prot) | ((en ? wd : old) & prot);
  endfunction
endpackage

// ===== hw/uefc_top.sv
// uefc_top: per-channel enhanced flow control, RS-485 direction and register file
// assumes a UART core that supplies fifo levels, trigger levels, bit ticks and tx status
//
// Functional notes
// [RULE1] scratch register, 8 bits, reset value FF, kept across sleep.
// [RULE2] hysteresis field used only with trigger table D; zero means next level.
// [RULE3] hysteresis field decodes to 0..52 characters per fixed table.
// [RULE4] hysteresis applied plus and minus around the receive trigger level.
// [RULE5] infrared polarity bit 1 inverts received encoded data.
// [RULE6] auto RS-485 bit overrides the external half-duplex select pin.
// [RULE7] RS-485: RTS drops to 0 after last stop bit leaves shift register.
// [RULE8] RS-485: RTS returns to 1 when a byte is loaded.
// [RULE9] tx interrupt source: shift empty in RS-485, holding empty otherwise.
// [RULE10] RS-485 turnaround delayed 0..15 bit times by write-only field.
// [RULE11] table select; tables A-C use next trigger level above and below.
// [RULE12] upper software-flow bits select which Xon/Xoff characters are sent.
// [RULE13] lower software-flow bits select which Xon/Xoff characters are compared.
// [RULE14] dual modes send or match two characters consecutively.
// [RULE15] software clears all flow-select bits before a new setting.
// [RULE16] enhanced-enable bit gates writes to the protected enhanced bits.
// [RULE17] protected enhanced bits reset to zero.
// [RULE18] special-character detect compares with Xoff2, stores, sets status bit 4.
// [RULE19] compare mode 01: matching Xoff2 not stored, sets both flags.
// [RULE20] auto RTS/DTR deasserts at upper level, reasserts below lower level.
// [RULE21] software asserts RTS/DTR before auto control acts; else plain output.
// [RULE22] modem-control bit 2 picks RTS/CTS or DTR/DSR pair.
// [RULE23] auto CTS/DSR stops transmit on input 1, resumes on 0.
// [RULE24] current character finishes before a flow-control halt.
// [RULE25] tables A-C ignore a nonzero hysteresis field.
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module uefc_top
  import uefc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [6:0]  rx_level,
  input  wire logic [6:0]  rx_trig,
  input  wire logic [6:0]  rx_trig_next_up,
  input  wire logic [6:0]  rx_trig_next_dn,
  input  wire uefc_char_t  rx_in,
  output uefc_char_t       rx_store,
  output logic             rx_trig_hit,
  input  wire logic        tx_load,
  input  wire logic        tx_holding_empty,
  input  wire logic        tx_shift_empty,
  input  wire logic        tx_char_busy,
  input  wire logic        bit_tick,
  output logic             tx_enable,
  output logic             tx_irq_src,
  output uefc_char_t       sw_tx,
  input  wire logic        sw_tx_ready,
  input  wire logic        ir_rx_raw,
  output logic             ir_rx_data,
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  input  wire logic        half_duplex_select_pin_n,
  output logic             rts_n,
  output logic             dtr_n
);
  // ****************************************
  // bus slave
  // ****************************************
  logic [7:0] scratch, feat, enh, xon1, xon2, xoff1, xoff2;
  logic [7:0] ien, fifo_ctl, modem, delay_reg, stat;
  logic       busy;
  logic       wr;
  logic [7:0] wd;
  logic [7:0] next_rdata;

  // one wait state: request seen, answered at the following edge
  assign avs_waitrequest = (avs_read | avs_write) & ~busy;
  assign wr = avs_write & busy;
  assign wd = avs_writedata[7:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (avs_read | avs_write) & ~busy;
    end
  end

  always_comb begin
    next_rdata = ZERO8;
    if (avs_address == A_SCRATCH) begin
      next_rdata = scratch;
    end else if (avs_address == A_FEAT) begin
      next_rdata = feat;
    end else if (avs_address == A_ENH) begin
      next_rdata = enh;
    end else if (avs_address == A_XON1) begin
      next_rdata = xon1;
    end else if (avs_address == A_XON2) begin
      next_rdata = xon2;
    end else if (avs_address == A_XOFF1) begin
      next_rdata = xoff1;
    end else if (avs_address == A_XOFF2) begin
      next_rdata = xoff2;
    end else if (avs_address == A_IEN) begin
      next_rdata = ien;
    end else if (avs_address == A_FIFO) begin
      next_rdata = fifo_ctl;
    end else if (avs_address == A_MODEM) begin
      next_rdata = modem;
    end else if (avs_address == A_STAT) begin
      next_rdata = stat;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~busy) begin
      avs_readdata <= {24'h00_0000, next_rdata};
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      scratch   <= SCRATCH_RST; // RULE1
      feat      <= ZERO8;
      enh       <= ZERO8;
      xon1      <= ZERO8;
      xon2      <= ZERO8;
      xoff1     <= ZERO8;
      xoff2     <= ZERO8;
      ien       <= ZERO8; // RULE17
      fifo_ctl  <= ZERO8;
      modem     <= ZERO8;
      delay_reg <= ZERO8;
    end else if (wr) begin
      if (avs_address == A_SCRATCH) begin
        scratch <= wd;
      end else if (avs_address == A_FEAT) begin
        feat <= wd;
      end else if (avs_address == A_ENH) begin
        enh <= wd;
      end else if (avs_address == A_XON1) begin
        xon1 <= wd;
      end else if (avs_address == A_XON2) begin
        xon2 <= wd;
      end else if (avs_address == A_XOFF1) begin
        xoff1 <= wd;
      end else if (avs_address == A_XOFF2) begin
        xoff2 <= wd;
      end else if (avs_address == A_IEN) begin
        ien <= uefc_merge(ien, wd, IEN_PROT, enh[EF_ENH]); // RULE16
      end else if (avs_address == A_FIFO) begin
        fifo_ctl <= uefc_merge(fifo_ctl, wd, FIFO_PROT, enh[EF_ENH]); // RULE16
      end else if (avs_address == A_MODEM) begin
        modem <= uefc_merge(modem, wd, MODEM_PROT, enh[EF_ENH]); // RULE16
      end else if (avs_address == A_DELAY) begin
        delay_reg <= uefc_merge(delay_reg, wd, DELAY_PROT, enh[EF_ENH]) & DELAY_PROT;
      end
    end
  end

  // ****************************************
  // thresholds and receive throttle
  // ****************************************
  logic       use_hyst;
  logic [7:0] hyst, trig8, up_thr, dn_thr, level8;
  logic       throttle;

  assign use_hyst = (feat[7:6] == TBL_D) && (feat[3:0] != HYST_OFF); // RULE2 RULE25 RULE11
  assign hyst     = uefc_hyst(feat[3:0]); // RULE3
  assign trig8    = {1'b0, rx_trig};
  assign level8   = {1'b0, rx_level};
  assign up_thr   = use_hyst ? trig8 + hyst : {1'b0, rx_trig_next_up}; // RULE4
  assign dn_thr   = use_hyst ? ((trig8 > hyst) ? trig8 - hyst : ZERO8)
                             : {1'b0, rx_trig_next_dn}; // RULE4

  always_ff @(posedge clk) begin
    if (rst) begin
      throttle    <= 1'b0;
      rx_trig_hit <= 1'b0;
    end else begin
      rx_trig_hit <= level8 >= trig8;
      if (level8 >= up_thr) begin
        throttle <= 1'b1; // RULE20
      end else if (level8 < dn_thr) begin
        throttle <= 1'b0; // RULE20
      end
    end
  end

  // ****************************************
  // receive compare
  // ****************************************
  logic [1:0] rxm, txm;
  logic       dual_rx, m_on, m_off, pend_on, pend_off, spc_hit, remote_off;

  assign rxm     = enh[1:0];
  assign txm     = enh[3:2];
  assign dual_rx = (rxm == SWF_BOTH) && ((txm == SWF_NONE) || (txm == SWF_BOTH)); // RULE14

  always_comb begin
    m_on  = 1'b0;
    m_off = 1'b0;
    case (rxm) // RULE13
      SWF_1: begin
        m_on  = rx_in.data == xon1;
        m_off = rx_in.data == xoff1;
      end
      SWF_2: begin
        m_on  = rx_in.data == xon2;
        m_off = rx_in.data == xoff2;
      end
      SWF_BOTH: begin
        if (dual_rx) begin
          m_on  = pend_on & (rx_in.data == xon2);
          m_off = pend_off & (rx_in.data == xoff2);
        end else begin
          m_on  = (rx_in.data == xon1) | (rx_in.data == xon2);
          m_off = (rx_in.data == xoff1) | (rx_in.data == xoff2);
        end
      end
      default: begin
        m_on  = 1'b0;
        m_off = 1'b0;
      end
    endcase
    m_on  = m_on & rx_in.valid;
    m_off = m_off & rx_in.valid;
  end

  assign spc_hit = rx_in.valid & enh[EF_SPC] & (rx_in.data == xoff2); // RULE18

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_on    <= 1'b0;
      pend_off   <= 1'b0;
      remote_off <= 1'b0;
      rx_store   <= '0;
    end else begin
      if (rx_in.valid) begin
        pend_on  <= dual_rx & (rx_in.data == xon1); // RULE14
        pend_off <= dual_rx & (rx_in.data == xoff1); // RULE14
      end
      if (rxm == SWF_NONE) begin
        remote_off <= 1'b0;
      end else if (m_off) begin
        remote_off <= 1'b1;
      end else if (m_on) begin
        remote_off <= 1'b0;
      end
      // matched flow characters stay out of the fifo, except the first of a dual pair; all other characters, special ones included, are kept
      rx_store.valid <= rx_in.valid & ~m_on & ~m_off; // RULE18 RULE19
      rx_store.data  <= rx_in.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stat[7:6] <= 2'b00;
      stat[3:0] <= 4'h0;
      stat[ST_SPC]  <= 1'b0;
      stat[ST_XOFF] <= 1'b0;
    end else begin
      stat[0] <= rts_n;
      stat[1] <= dtr_n;
      stat[2] <= tx_enable;
      stat[3] <= remote_off;
      stat[7:6] <= 2'b00;
      // a new event wins over a clear in the same cycle
      if (spc_hit) begin
        stat[ST_SPC] <= 1'b1; // RULE18 RULE19
      end else if (wr && avs_address == A_STAT && enh[EF_ENH] && wd[ST_SPC]) begin
        stat[ST_SPC] <= 1'b0; // RULE16
      end
      if (m_off) begin
        stat[ST_XOFF] <= 1'b1; // RULE19
      end else if (wr && avs_address == A_STAT && enh[EF_ENH] && wd[ST_XOFF]) begin
        stat[ST_XOFF] <= 1'b0; // RULE16
      end
    end
  end

  // ****************************************
  // software flow transmit
  // ****************************************
  uefc_swtx_t sw_st;
  logic       sw_sent_off, sw_sending_off;
  logic [7:0] sw_data;

  assign sw_tx = {sw_st != S_IDLE, sw_data};

  always_ff @(posedge clk) begin
    if (rst) begin
      sw_st          <= S_IDLE;
      sw_sent_off    <= 1'b0;
      sw_sending_off <= 1'b0;
      sw_data        <= ZERO8;
    end else begin
      case (sw_st)
        S_IDLE: begin
          if (txm == SWF_NONE) begin
            sw_sent_off <= 1'b0;
          end else if (throttle != sw_sent_off) begin
            sw_sending_off <= throttle;
            sw_st          <= S_FIRST;
            if (txm == SWF_2) begin
              sw_data <= throttle ? xoff2 : xon2; // RULE12
            end else begin
              sw_data <= throttle ? xoff1 : xon1; // RULE12
            end
          end
        end
        S_FIRST: begin
          if (sw_tx_ready) begin
            if (txm == SWF_BOTH) begin
              sw_st      <= S_SECOND; // RULE14
              sw_data <= sw_sending_off ? xoff2 : xon2;
            end else begin
              sw_st       <= S_IDLE;
              sw_sent_off <= sw_sending_off;
            end
          end
        end
        S_SECOND: begin
          if (sw_tx_ready) begin
            sw_st       <= S_IDLE;
            sw_sent_off <= sw_sending_off;
          end
        end
        default: begin
          sw_st <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // RS-485 direction and modem outputs
  // ****************************************
  uefc_dir_t  dir_st;
  logic [3:0] dly_cnt, dly_bits;
  logic       auto485, tx_idle, hw_stop;

  assign auto485  = feat[FC_AUTO485] | ~half_duplex_select_pin_n; // RULE6
  assign dly_bits = delay_reg[7:4];
  assign tx_idle  = tx_shift_empty & tx_holding_empty & ~tx_load;
  assign hw_stop  = enh[EF_ACTS] & (modem[MC_SEL] ? dsr_n : cts_n); // RULE22 RULE23

  always_ff @(posedge clk) begin
    if (rst || !auto485) begin
      dir_st  <= R_RX;
      dly_cnt <= CNT_ZERO;
    end else begin
      case (dir_st)
        R_RX: begin
          if (tx_load) begin
            dir_st <= R_TX; // RULE8
          end
        end
        R_TX: begin
          if (tx_idle) begin
            dly_cnt <= CNT_ZERO;
            dir_st  <= (dly_bits == CNT_ZERO) ? R_RX : R_DLY; // RULE7
          end
        end
        R_DLY: begin
          if (tx_load) begin
            dir_st <= R_TX; // RULE8
          end else if (bit_tick) begin
            dly_cnt <= dly_cnt + CNT_ONE; // RULE10
            if (dly_cnt + CNT_ONE == dly_bits) begin
              dir_st <= R_RX; // RULE10
            end
          end
        end
        default: begin
          dir_st <= R_RX;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rts_n      <= 1'b1;
      dtr_n      <= 1'b1;
      tx_enable  <= 1'b1;
      tx_irq_src <= 1'b0;
      ir_rx_data <= 1'b0;
    end else begin
      if (auto485) begin
        rts_n <= dir_st != R_RX; // RULE7 RULE8
      end else begin
        rts_n <= ~modem[MC_RTS] | (enh[EF_ARTS] & ~modem[MC_SEL] & throttle); // RULE21 RULE22
      end
      dtr_n <= ~modem[MC_DTR] | (enh[EF_ARTS] & modem[MC_SEL] & throttle); // RULE21 RULE22
      if (!tx_char_busy) begin
        tx_enable <= ~(hw_stop | remote_off); // RULE23 RULE24
      end
      tx_irq_src <= auto485 ? tx_shift_empty : tx_holding_empty; // RULE9
      ir_rx_data <= ir_rx_raw ^ feat[FC_IRPOL]; // RULE5
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_last_bit;
    auto485 && dir_st == R_TX && tx_idle && dly_bits == CNT_ZERO;
  endsequence
  sequence s_rts_low;
    auto485 [*2] ##0 !rts_n;
  endsequence
  property p_scr_rst;
    @(posedge clk) disable iff (rst) $fell(rst) |-> scratch == SCRATCH_RST && ien == ZERO8;
  endproperty
  a_scr_rst: assert property (p_scr_rst) else $error("scratch or ien bad after reset"); // RULE1
  property p_prot;
    @(posedge clk) disable iff (rst)
      wr && avs_address == A_IEN && !enh[EF_ENH] |=> ien[7:4] == $past(ien[7:4]);
  endproperty
  a_prot: assert property (p_prot) else $error("protected bits changed"); // RULE16
  property p_irpol;
    @(posedge clk) disable iff (rst) ##1 ir_rx_data == ($past(ir_rx_raw) ^ $past(feat[FC_IRPOL]));
  endproperty
  a_irpol: assert property (p_irpol) else $error("ir polarity wrong"); // RULE5
  property p_txirq;
    @(posedge clk) disable iff (rst) auto485 && $stable(auto485) && !tx_shift_empty
      |=> !tx_irq_src;
  endproperty
  a_txirq: assert property (p_txirq) else $error("tx irq source wrong"); // RULE9
  property p_rts_up;
    @(posedge clk) disable iff (rst) auto485 && tx_load ##1 auto485 |-> ##1 rts_n;
  endproperty
  a_rts_up: assert property (p_rts_up) else $error("rts not raised on load"); // RULE8
  property p_rts_down;
    @(posedge clk) disable iff (rst) s_last_bit ##1 !tx_load |-> s_rts_low;
  endproperty
  a_rts_down: assert property (p_rts_down) else $error("rts not dropped"); // RULE7
  property p_dly;
    @(posedge clk) disable iff (rst) dir_st == R_DLY |-> dly_cnt < dly_bits;
  endproperty
  a_dly: assert property (p_dly) else $error("turnaround delay overrun"); // RULE10
  property p_thr;
    @(posedge clk) disable iff (rst) use_hyst && level8 >= trig8 + hyst |=> throttle;
  endproperty
  a_thr: assert property (p_thr) else $error("no throttle at upper level"); // RULE4
  property p_cts;
    @(posedge clk) disable iff (rst) hw_stop && !tx_char_busy |=> !tx_enable;
  endproperty
  a_cts: assert property (p_cts) else $error("tx not halted"); // RULE23
  property p_x2;
    @(posedge clk) disable iff (rst) rx_in.valid && rxm == SWF_2 && rx_in.data == xoff2
      |=> !rx_store.valid && stat[ST_XOFF];
  endproperty
  a_x2: assert property (p_x2) else $error("xoff2 stored"); // RULE19
  property p_spc;
    @(posedge clk) disable iff (rst) spc_hit |=> stat[ST_SPC];
  endproperty
  a_spc: assert property (p_spc) else $error("special flag missing"); // RULE18
  property p_dual;
    @(posedge clk) disable iff (rst) sw_st == S_FIRST && sw_tx_ready && txm == SWF_BOTH
      |=> sw_st == S_SECOND;
  endproperty
  a_dual: assert property (p_dual) else $error("second char skipped"); // RULE14
endmodule

// ===== verification/uefc_remote.sv
// uefc_remote: remote serial party facing the flow control block
// assumes the bench sets stop and slow; drives cts_n/dsr_n and accepts flow chars
`timescale 1ns/1ps
module uefc_remote
  import uefc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       stop,
  input  wire logic       slow,
  input  wire uefc_char_t sw_tx,
  output logic            sw_tx_ready,
  output logic            cts_n,
  output logic            dsr_n,
  output logic [15:0]     got
);
  // ****************************************
  // throttle pins and flow char sink
  // ****************************************
  logic [1:0] wt = 2'h0;
  initial begin
    sw_tx_ready = 1'b0;
    cts_n = 1'b0;
    dsr_n = 1'b0;
    got = 16'h0000;
  end
  always @(posedge clk) begin
    cts_n <= stop;
    dsr_n <= stop;
  end
  // slow mode holds each char four cycles before accepting
  always @(posedge clk) begin
    if (sw_tx.valid && !sw_tx_ready) begin
      wt <= wt + 2'h1;
      sw_tx_ready <= !slow || (wt == 2'h3);
    end else begin
      wt <= 2'h0;
      sw_tx_ready <= 1'b0;
    end
    if (sw_tx.valid && sw_tx_ready) begin
      got <= {got[7:0], sw_tx.data};
    end
  end
endmodule

// ===== verification/testbench.sv
// testbench: register, flow control and RS-485 checks of uefc_top
// assumes uefc_remote as the far side and the bench as the UART core
`timescale 1ns/1ps
module testbench
  import uefc_pkg::*;
;
  // ****************************************
  // signals and instances
  // ****************************************
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, ld = 1'b0, hemp = 1'b1;
  logic        semp = 1'b1, busy = 1'b0, tick = 1'b0, ir = 1'b0, pin_n = 1'b1;
  logic        stop = 1'b0, slow = 1'b1, wq, hit, ten, irq, ir_out, cts_n, dsr_n;
  logic        rts_n, dtr_n, rdy;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic [6:0]  lvl = 7'h00, trg = 7'h20, up = 7'h28, dn = 7'h08;
  logic [7:0]  q;
  logic [15:0] got;
  uefc_char_t  rxi = '0, rxs, swt;
  int          failures = 0, samples_checked = 0;

  uefc_top DUT (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wq), .rx_level(lvl),
    .rx_trig(trg), .rx_trig_next_up(up), .rx_trig_next_dn(dn), .rx_in(rxi), .rx_store(rxs),
    .rx_trig_hit(hit), .tx_load(ld), .tx_holding_empty(hemp), .tx_shift_empty(semp),
    .tx_char_busy(busy), .bit_tick(tick), .tx_enable(ten), .tx_irq_src(irq), .sw_tx(swt),
    .sw_tx_ready(rdy), .ir_rx_raw(ir), .ir_rx_data(ir_out), .cts_n(cts_n), .dsr_n(dsr_n),
    .half_duplex_select_pin_n(pin_n), .rts_n(rts_n), .dtr_n(dtr_n));
  uefc_remote far (.clk(clk), .stop(stop), .slow(slow), .sw_tx(swt), .sw_tx_ready(rdy),
    .cts_n(cts_n), .dsr_n(dsr_n), .got(got));

  always #2.5 clk = ~clk;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic wrap_up();
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    if (wq !== 1'b0) begin
      failures++;
      wrap_up();
    end
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic w8(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input string nm, input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {8'h00, e}, {8'h00, q});
  endtask
  task automatic lvls(input logic [27:0] l, input logic [7:0] e);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      lvl <= l[i*7 +: 7];
      cyc(4);
      chk("pins", {14'h0, e[i*2 +: 2]}, {14'h0, rts_n, dtr_n});
      chk("trig", {15'h0, l[i*7 +: 7] >= trg}, {15'h0, hit});
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rchk("scratch", A_SCRATCH, 8'hFF);
    rchk("modem", A_MODEM, 8'h00);
    rchk("ien", A_IEN, 8'h00);
    w8(A_SCRATCH, 8'h5A);
    rchk("scratch", A_SCRATCH, 8'h5A);
    w8(6'h3C, 8'h77);
    rchk("unmapped", 6'h3C, 8'h00);
    w8(A_ENH, 8'h10);
    w8(A_DELAY, 8'hF0);
    rchk("delay", A_DELAY, 8'h00);
  endtask
  task automatic t_prot();
    w8(A_ENH, 8'h00);
    w8(A_IEN, 8'hFF);
    rchk("ien", A_IEN, 8'h0F);
    w8(A_ENH, 8'h10);
    w8(A_IEN, 8'hFF);
    w8(A_ENH, 8'h00);
    w8(A_IEN, 8'h00);
    rchk("ien", A_IEN, 8'hF0);
  endtask
  task automatic t_ir();
    @(posedge clk);
    ir <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      w8(A_FEAT, {3'h0, p[0], 4'h0});
      cyc(2);
      chk("ir", {15'h0, ~p[0]}, {15'h0, ir_out});
    end
  endtask
  task automatic t_hyst();
    w8(A_MODEM, 8'h02);
    w8(A_ENH, 8'h40);
    w8(A_FEAT, 8'hC1);
    lvls({7'd27, 7'd28, 7'd36, 7'd35}, 8'h7D);
    w8(A_FEAT, 8'h41);
    lvls({7'd7, 7'd8, 7'd40, 7'd36}, 8'h7D);
    w8(A_MODEM, 8'h05);
    lvls({7'd7, 7'd8, 7'd40, 7'd36}, 8'hBE);
  endtask
  task automatic t_485();
    w8(A_ENH, 8'h10);
    w8(A_DELAY, 8'h20);
    w8(A_FEAT, 8'h20);
    @(posedge clk);
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    hemp <= 1'b0;
    semp <= 1'b0;
    cyc(3);
    chk("rts_load", 16'h1, {15'h0, rts_n});
    @(posedge clk);
    hemp <= 1'b1;
    cyc(2);
    chk("irq_shift", 16'h0, {15'h0, irq});
    @(posedge clk);
    semp <= 1'b1;
    for (int t = 0; t < 2; t++) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      cyc(4);
      chk("rts_turn", {15'h0, t == 0}, {15'h0, rts_n});
    end
    w8(A_DELAY, 8'h00);
    @(posedge clk);
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    cyc(3);
    chk("rts_nodly", 16'h0, {15'h0, rts_n});
    w8(A_FEAT, 8'h00);
    @(posedge clk);
    semp <= 1'b0;
    pin_n <= 1'b0;
    cyc(3);
    chk("irq_pin", 16'h0, {15'h0, irq});
    @(posedge clk);
    pin_n <= 1'b1;
    cyc(3);
    chk("irq_std", 16'h1, {15'h0, irq});
  endtask
  task automatic t_cts();
    w8(A_MODEM, 8'h00);
    w8(A_ENH, 8'h80);
    @(posedge clk);
    busy <= 1'b1;
    stop <= 1'b1;
    cyc(4);
    chk("ten_busy", 16'h1, {15'h0, ten});
    @(posedge clk);
    busy <= 1'b0;
    cyc(4);
    chk("ten_stop", 16'h0, {15'h0, ten});
    @(posedge clk);
    stop <= 1'b0;
    cyc(4);
    chk("ten_go", 16'h1, {15'h0, ten});
  endtask
  task automatic t_sw();
    logic [7:0]  m[4] = '{8'h0C, 8'h0C, 8'h08, 8'h04};
    logic [6:0]  l[4] = '{7'd40, 7'd0, 7'd40, 7'd0};
    logic [15:0] x[4] = '{16'h1393, 16'h1191, 16'h9113, 16'h9391};
    w8(A_XON1, 8'h11);
    w8(A_XON2, 8'h91);
    w8(A_XOFF1, 8'h13);
    w8(A_XOFF2, 8'h93);
    for (int i = 0; i < 4; i++) begin
      w8(A_ENH, 8'h00);
      w8(A_ENH, m[i]);
      lvl <= l[i];
      cyc(40);
      chk("sw_tx", x[i], got);
    end
  endtask
  task automatic t_rx();
    logic [7:0] en[4] = '{8'h32, 8'h31, 8'h12, 8'h1B};
    logic [7:0] d[4] = '{8'h93, 8'h93, 8'h13, 8'h93};
    logic [7:0] s[4] = '{8'h10, 8'h38, 8'h28, 8'h28};
    for (int i = 0; i < 4; i++) begin
      w8(A_ENH, 8'h00);
      w8(A_ENH, en[i]);
      w8(A_STAT, 8'h30);
      rxi <= {1'b1, d[i]};
      @(posedge clk);
      rxi <= '0;
      @(negedge clk);
      chk("stored", {7'h0, i == 0, d[i]}, {7'h0, rxs});
      bus(1'b0, A_STAT, 8'h00);
      chk("status", {8'h00, s[i]}, {8'h00, q & 8'h38});
    end
    w8(A_ENH, 8'h00);
    w8(A_ENH, 8'h13);
    w8(A_STAT, 8'h30);
    rxi <= {1'b1, 8'h13};
    @(posedge clk);
    rxi <= {1'b1, 8'h93};
    @(posedge clk);
    rxi <= '0;
    @(negedge clk);
    chk("dual", {7'h0, 9'h093}, {7'h0, rxs});
    bus(1'b0, A_STAT, 8'h00);
    chk("dual_st", 16'h0028, {8'h00, q & 8'h38});
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_prot();
    t_ir();
    t_hyst();
    t_485();
    t_cts();
    t_sw();
    t_rx();
    wrap_up();
  end
endmodule
